// [logic/aiglc_core.sv]
// Purpose: Automatic input gain level control and peak limiter with AXI4-Lite registers
// Assumes: sample_valid pulses once per audio sample with sample_data
// Notes:   amp_gain steps 0.75 dB per code, 0x00 is the lowest gain
`timescale 1ns/1ps
module aiglc_core
    import aiglc_pkg::*;
#(
    parameter int NORM_ATK_CYCLES = NORM_ATK_CYC,
    parameter int NORM_DCY_CYCLES = NORM_DCY_CYC,
    parameter int HOLD_CYCLES     = HOLD_CYC
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic signed [15:0] sample_data,
    input  wire logic              sample_valid,
    output logic [GAIN_W-1:0]      amp_gain
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Per-step interval doubling per code, saturating
    function automatic logic [TMR_W-1:0] rate_interval(input int base, input logic [3:0] code);
        logic [3:0] c;
        c = (code > RATE_SAT) ? RATE_SAT : code;
        return TMR_W'(TMR_W'(base) << c);
    endfunction : rate_interval

    // ************************************************************
    // Register state
    // ************************************************************
    logic [8:0]        ctl1;
    logic [8:0]        ctl2;
    logic [8:0]        ctl3;
    logic [2:0]        sample_rate_select;
    logic [GAIN_W-1:0] start_gain;
    logic [15:0]       peak;
    logic              hold_ok;
    logic [7:0]        frac_acc;
    logic              unit_en;
    aiglc_state_t      state;
    aiglc_state_t      next_state;

    // Field views
    wire logic [2:0] gain_floor          = ctl1[FLOOR_LSB +: 3];
    wire logic [2:0] gain_ceiling        = ctl1[CEIL_LSB +: 3];
    wire logic       level_control_enable = ctl1[EN_BIT];
    wire logic [3:0] target_level        = ctl2[TARGET_LSB +: 4];
    wire logic [3:0] gain_hold_time      = ctl2[HOLD_LSB +: 4];
    wire logic [3:0] gain_fall_rate      = ctl3[FALL_LSB +: 4];
    wire logic [3:0] gain_rise_rate      = ctl3[RISE_LSB +: 4];
    wire logic       limiter_mode_select = ctl3[MODE_BIT];

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic       aw_full;
    logic       w_full;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    wire logic wr_fire   = aw_full && w_full && !s_axi_bvalid;
    wire logic wr_ctl1   = wr_fire && (aw_addr_q == ADDR_CTL1);
    wire logic wr_ctl2   = wr_fire && (aw_addr_q == ADDR_CTL2);
    wire logic wr_ctl3   = wr_fire && (aw_addr_q == ADDR_CTL3);
    wire logic wr_srate  = wr_fire && (aw_addr_q == ADDR_SRATE);
    wire logic wr_vol    = wr_fire && (aw_addr_q == ADDR_VOL);
    wire logic wr_hit    = wr_ctl1 || wr_ctl2 || wr_ctl3 || wr_srate || wr_vol;
    wire logic [31:0] wr_ctl1_v  = merge_bytes({23'h0, ctl1}, w_data_q, w_strb_q);
    wire logic [31:0] wr_ctl2_v  = merge_bytes({23'h0, ctl2}, w_data_q, w_strb_q);
    wire logic [31:0] wr_ctl3_v  = merge_bytes({23'h0, ctl3}, w_data_q, w_strb_q);
    wire logic [31:0] wr_srate_v = merge_bytes({29'h0, sample_rate_select}, w_data_q, w_strb_q);
    wire logic [31:0] wr_vol_v   = merge_bytes({26'h0, amp_gain}, w_data_q, w_strb_q);

    // Capture address and data in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl1               <= RST_CTL1;
            ctl2               <= RST_CTL2;
            ctl3               <= RST_CTL3;
            sample_rate_select <= RST_SRATE;
        end else begin
            if (wr_ctl1) ctl1 <= wr_ctl1_v[8:0] & CTL1_MASK;
            if (wr_ctl2) ctl2 <= wr_ctl2_v[8:0] & CTL2_MASK;
            if (wr_ctl3) ctl3 <= wr_ctl3_v[8:0] & CTL3_MASK;
            if (wr_srate) sample_rate_select <= wr_srate_v[2:0];
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    wire logic rd_fire = s_axi_arvalid && s_axi_arready;
    wire logic [31:0] status_word = {12'h000, !hold_ok, 1'b0, 1'b0, 1'b0, 16'h0000} & 32'h0;
    logic [31:0] rd_mux;
    logic        rd_hit;

    assign s_axi_arready = !s_axi_rvalid;

    // Read data select
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_CTL1:  rd_mux = {23'h0, ctl1};
            ADDR_CTL2:  rd_mux = {23'h0, ctl2};
            ADDR_CTL3:  rd_mux = {23'h0, ctl3};
            ADDR_SRATE: rd_mux = {29'h0, sample_rate_select};
            ADDR_VOL:   rd_mux = {26'h0, amp_gain};
            ADDR_STAT: begin
                rd_mux               = status_word;
                rd_mux[GAIN_W-1:0]   = amp_gain;
                rd_mux[ST_START_LSB +: GAIN_W] = start_gain;
                rd_mux[ST_ACT_BIT]   = (state != ST_OFF);
                rd_mux[ST_LIM_BIT]   = (state == ST_LIMIT);
                rd_mux[ST_HOLD_BIT]  = !hold_ok;
                rd_mux[ST_ABOVE_BIT] = (peak > LEVEL_THRESH[target_level]);
            end
            default:    rd_hit = 1'b0;
        endcase
    end

    // Read answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Sample-rate scaled unit enable
    // ************************************************************
    wire logic       family_44k = (sample_rate_select == 3'h1) || (sample_rate_select == 3'h4) ||
                                  (sample_rate_select == 3'h6);
    wire logic [8:0] frac_sum   = {1'b0, frac_acc} + {1'b0, SR_NUM};
    wire logic       frac_wrap  = (frac_sum >= {1'b0, SR_DEN});

    // Fractional divider stretches all intervals for the 44.1 kHz family
    always_ff @(posedge aclk) begin
        if (!aresetn || !family_44k) begin
            frac_acc <= 8'h00;
            unit_en  <= aresetn;
        end else begin
            frac_acc <= frac_wrap ? 8'(frac_sum - {1'b0, SR_DEN}) : frac_sum[7:0];
            unit_en  <= frac_wrap;
        end
    end

    // ************************************************************
    // Loop mode control
    // ************************************************************
    wire logic loop_run = (state != ST_OFF);

    // Mode selection from enable and mode bits
    always_comb begin
        case (state)
            ST_OFF, ST_NORMAL, ST_LIMIT: begin
                if (!level_control_enable) next_state = ST_OFF;
                else if (limiter_mode_select) next_state = ST_LIMIT;
                else next_state = ST_NORMAL;
            end
            default: next_state = ST_OFF;
        endcase
    end

    // State and limiter starting level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= ST_OFF;
            start_gain <= RST_GAIN;
        end else begin
            state <= next_state;
            if (next_state == ST_LIMIT && state != ST_LIMIT) begin
                start_gain <= amp_gain;
            end
        end
    end

    // ************************************************************
    // Peak detector
    // ************************************************************
    logic step_tick;
    logic hold_done;
    wire logic [15:0] sample_abs = sample_data[15] ? 16'(-sample_data) : sample_data;
    wire logic [15:0] thresh     = LEVEL_THRESH[target_level];
    wire logic        above      = (peak > thresh);

    // Largest magnitude since the last gain decision
    always_ff @(posedge aclk) begin
        if (!aresetn || !loop_run) begin
            peak <= 16'h0000;
        end else if (step_tick) begin
            peak <= sample_valid ? sample_abs : 16'h0000;
        end else if (sample_valid && sample_abs > peak) begin
            peak <= sample_abs;
        end
    end

    // ************************************************************
    // Step and hold timing
    // ************************************************************
    wire logic [TMR_W-1:0] atk_int = limiter_mode_select ? rate_interval(LIM_ATK_CYC, gain_fall_rate)
                                                         : rate_interval(NORM_ATK_CYCLES, gain_fall_rate);
    wire logic [TMR_W-1:0] dcy_int = limiter_mode_select ? rate_interval(LIM_DCY_CYC, gain_rise_rate)
                                                         : rate_interval(NORM_DCY_CYCLES, gain_rise_rate);
    wire logic [TMR_W-1:0] step_int = above ? atk_int : dcy_int;
    wire logic [3:0]       hold_m1  = (gain_hold_time > RATE_SAT) ? 4'h9 : 4'(gain_hold_time - 1'b1);
    wire logic [TMR_W-1:0] hold_int = rate_interval(HOLD_CYCLES, hold_m1);
    wire logic             hold_run = loop_run && !above && !hold_ok;

    aiglc_step_timer u_step_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (loop_run),
        .unit_en (unit_en),
        .limit   (step_int),
        .done    (step_tick)
    );

    aiglc_step_timer u_hold_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (hold_run),
        .unit_en (unit_en),
        .limit   (hold_int),
        .done    (hold_done)
    );

    // Hold must elapse below threshold before gain may rise
    always_ff @(posedge aclk) begin
        if (!aresetn || !loop_run || above) begin
            hold_ok <= 1'b0;
        end else if (gain_hold_time == 4'h0 || hold_done) begin
            hold_ok <= 1'b1;
        end
    end

    // ************************************************************
    // Gain update
    // ************************************************************
    wire logic [5:0] lo_lim  = {gain_floor, 3'h0};
    wire logic [5:0] hi_norm = {gain_ceiling, 3'h0} | CEIL_OFFSET;
    wire logic [5:0] hi_lim  = (state == ST_LIMIT && start_gain < hi_norm) ? start_gain : hi_norm;
    wire logic [5:0] gain_dn = (amp_gain != 6'h00) ? 6'(amp_gain - 1'b1) : amp_gain;
    wire logic [5:0] gain_up = (amp_gain != 6'h3F) ? 6'(amp_gain + 1'b1) : amp_gain;
    wire logic [5:0] gain_raw = above ? gain_dn : (hold_ok ? gain_up : amp_gain);
    wire logic [5:0] gain_hi  = (gain_raw > hi_lim) ? hi_lim : gain_raw;
    wire logic [5:0] next_gain = (gain_hi < lo_lim) ? lo_lim : gain_hi;

    // Loop steps gain; host writes only while the loop is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amp_gain <= RST_GAIN;
        end else if (loop_run) begin
            if (step_tick) begin
                amp_gain <= next_gain;
            end
        end else if (wr_vol) begin
            amp_gain <= wr_vol_v[GAIN_W-1:0];
        end
    end // Otherwise held

endmodule : aiglc_core

// [logic/aiglc_pkg.sv]
// Purpose: Constants, register map and types for the input gain level control
// Assumes: 40 MHz aclk, AXI4-Lite register access, 16-bit signed audio samples
// Notes:   Register byte address is four times the register index

package aiglc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_MHZ     = 40;
    localparam int NORM_ATK_NS = 104000;
    localparam int NORM_DCY_NS = 410000;
    localparam int LIM_ATK_NS  = 22700;
    localparam int LIM_DCY_NS  = 90800;
    localparam int HOLD_NS     = 2665000;
    localparam int NORM_ATK_CYC = (NORM_ATK_NS * CLK_MHZ + 999) / 1000;
    localparam int NORM_DCY_CYC = (NORM_DCY_NS * CLK_MHZ + 999) / 1000;
    localparam int LIM_ATK_CYC  = (LIM_ATK_NS * CLK_MHZ + 999) / 1000;
    localparam int LIM_DCY_CYC  = (LIM_DCY_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC     = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W        = 26;
    localparam logic [3:0] RATE_SAT = 4'hA;
    // 44.1 kHz family runs unit ticks at 147/160 of the clock
    localparam logic [7:0] SR_NUM = 8'h93;
    localparam logic [7:0] SR_DEN = 8'hA0;

    // ************************************************************
    // Register map (index, byte address)
    // ************************************************************
    localparam logic [7:0] IDX_SRATE = 8'h07;
    localparam logic [7:0] IDX_CTL1  = 8'h20;
    localparam logic [7:0] IDX_CTL2  = 8'h21;
    localparam logic [7:0] IDX_CTL3  = 8'h22;
    localparam logic [7:0] IDX_VOL   = 8'h2D;
    localparam logic [7:0] IDX_STAT  = 8'h2E;
    localparam logic [7:0] ADDR_SRATE = {IDX_SRATE[5:0], 2'h0};
    localparam logic [7:0] ADDR_CTL1  = {IDX_CTL1[5:0], 2'h0};
    localparam logic [7:0] ADDR_CTL2  = {IDX_CTL2[5:0], 2'h0};
    localparam logic [7:0] ADDR_CTL3  = {IDX_CTL3[5:0], 2'h0};
    localparam logic [7:0] ADDR_VOL   = {IDX_VOL[5:0], 2'h0};
    localparam logic [7:0] ADDR_STAT  = {IDX_STAT[5:0], 2'h0};

    // ************************************************************
    // Field positions and writable masks
    // ************************************************************
    localparam int FLOOR_LSB  = 0;
    localparam int CEIL_LSB   = 3;
    localparam int EN_BIT     = 8;
    localparam int TARGET_LSB = 0;
    localparam int HOLD_LSB   = 4;
    localparam int FALL_LSB   = 0;
    localparam int RISE_LSB   = 4;
    localparam int MODE_BIT   = 8;
    localparam int ST_START_LSB = 8;
    localparam int ST_ACT_BIT   = 16;
    localparam int ST_LIM_BIT   = 17;
    localparam int ST_HOLD_BIT  = 18;
    localparam int ST_ABOVE_BIT = 19;
    localparam logic [8:0] CTL1_MASK = 9'h13F;
    localparam logic [8:0] CTL2_MASK = 9'h0FF;
    localparam logic [8:0] CTL3_MASK = 9'h1FF;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [8:0] RST_CTL1  = 9'h038;
    localparam logic [8:0] RST_CTL2  = 9'h00B;
    localparam logic [8:0] RST_CTL3  = 9'h032;
    localparam logic [2:0] RST_SRATE = 3'h0;
    localparam logic [5:0] RST_GAIN  = 6'h10;

    // ************************************************************
    // Gain scale and level thresholds
    // ************************************************************
    localparam int GAIN_W = 6;
    localparam logic [5:0] CEIL_OFFSET = 6'h07;
    localparam logic [15:0] LEVEL_THRESH [0:15] = '{
        16'h04D0, 16'h05B8, 16'h06CC, 16'h0814, 16'h0999, 16'h0B69, 16'h0D8F, 16'h101D,
        16'h1327, 16'h16C3, 16'h1B0E, 16'h2027, 16'h2637, 16'h2D6A, 16'h35FA, 16'h4026};
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b001,
        ST_NORMAL = 3'b010,
        ST_LIMIT  = 3'b100
    } aiglc_state_t;

endpackage : aiglc_pkg

// [logic/aiglc_step_timer.sv]
// Purpose: Interval timer counting unit enables up to a limit
// Assumes: limit stable or changing only between intervals
// Notes:   done is a one-cycle registered pulse, timer restarts after it
`timescale 1ns/1ps
module aiglc_step_timer
    import aiglc_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic             unit_en,
    input  wire logic [TMR_W-1:0] limit,
    output logic                  done
);

    logic [TMR_W-1:0] count;
    wire logic [TMR_W-1:0] count_inc = TMR_W'(count + 1'b1);
    wire logic             reached   = (count_inc >= limit);

    // Count units, pulse and wrap at the limit
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            done <= unit_en && reached;
            if (unit_en) begin
                count <= reached ? '0 : count_inc;
            end
        end
    end

endmodule : aiglc_step_timer

// [verification/aiglc_checker.sv]
// Purpose: Port checks on the register bus of aiglc_core
// Assumes: one clock domain, aclk
// Notes:   Bound to every aiglc_core instance
`timescale 1ns/1ps
module aiglc_checker
    import aiglc_pkg::*;
#(
    parameter int NORM_ATK_CYCLES = 8,
    parameter int NORM_DCY_CYCLES = 16,
    parameter int HOLD_CYCLES     = 32
)
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ********************************************
    // Handshake timing
    // ********************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer lost");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read while busy");
    wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read has data");
endmodule : aiglc_checker

bind aiglc_core aiglc_checker #(.NORM_ATK_CYCLES(NORM_ATK_CYCLES), .NORM_DCY_CYCLES(NORM_DCY_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [verification/aiglc_partner.sv]
// Purpose: Audio source behind the input amplifier
// Assumes: one sample every four clocks
// Notes:   Level set by loud, sign alternates per sample
`timescale 1ns/1ps
module aiglc_partner (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          loud,
    output logic signed [15:0] sample_data,
    output logic               sample_valid
);
    // ********************************************
    // Sample pacing
    // ********************************************
    logic [1:0] phase;
    logic       flip;
    // Data line churns between samples
    always_ff @(posedge aclk) begin
        phase        <= aresetn ? phase + 2'h1 : 2'h0;
        flip         <= aresetn ? flip ^ (phase == 2'h3) : 1'b0;
        sample_valid <= aresetn && phase == 2'h3;
        sample_data  <= phase == 2'h3 ? (loud ? 16'h6000 : 16'h0100) ^ {16{flip}} : ~sample_data;
    end
endmodule : aiglc_partner

// [verification/aiglc_core_tb.sv]
// Purpose: Self-checking bench for aiglc_core
// Assumes: shortened normal counts 8/16/32
// Notes:   Reads are noted in a queue and checked on rvalid
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module aiglc_core_tb
    import aiglc_pkg::*;
;
    // ********************************************
    // Signals
    // ********************************************
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sample_valid, loud;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic signed [15:0] sample_data;
    logic [5:0] amp_gain, r;
    logic [65:0] q[$], nq;
    int mismatches = 0, total_checks = 0, seed = 85, n;
    aiglc_core #(.NORM_ATK_CYCLES(8), .NORM_DCY_CYCLES(16), .HOLD_CYCLES(32)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sample_data, .sample_valid, .amp_gain);
    aiglc_partner i_src (.aclk, .aresetn, .loud, .sample_data, .sample_valid);
    // ********************************************
    // Bus tasks and result monitor
    // ********************************************
    always #12.5 aclk = ~aclk;
    // Oldest note against each read answer
    always @(posedge aclk) if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
        nq = q.pop_front();
        `CHK({s_axi_rresp, s_axi_rdata & nq[63:32]}, {nq[65:64], nq[31:0]})
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid & ~aw) | (s_axi_wvalid & ~w));
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] m, input logic [31:0] e);
        q.push_back({rs, m, e});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    // Cycles between two gain steps
    task automatic meas(output int c);
        logic [5:0] g;
        @(negedge aclk);
        g = amp_gain;
        while (amp_gain === g) @(negedge aclk);
        g = amp_gain;
        c = 0;
        while (amp_gain === g) begin
            @(negedge aclk);
            c++;
        end
    endtask : meas
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    // ********************************************
    // Tests
    // ********************************************
    localparam logic [7:0] RA [6] = '{ADDR_CTL1, ADDR_CTL2, ADDR_CTL3, ADDR_VOL, ADDR_SRATE, 8'h00};
    localparam logic [31:0] RV [6] = '{32'h38, 32'h0B, 32'h32, 32'h10, 32'h0, 32'h0};
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, loud} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(RA[i], i == 5 ? RESP_SLVERR : RESP_OKAY, '1, RV[i]);
        wr(ADDR_VOL, 32'h20);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h20);
        $display("reset and host gain done");
        wr(ADDR_CTL3, 32'h000);
        loud <= 1'b1;
        wr(ADDR_CTL1, 32'h138);
        meas(n);
        `CHK(n, 8)
        wr(ADDR_CTL1, 32'h13B);
        repeat (300) @(posedge aclk);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h18);
        loud <= 1'b0;
        meas(n);
        `CHK(n, 16)
        wr(ADDR_CTL1, 32'h11B);
        repeat (300) @(posedge aclk);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h1F);
        wr(ADDR_VOL, 32'h05);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h1F);
        wr(ADDR_CTL1, 32'h01B);
        repeat (300) @(posedge aclk);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h1F);
        $display("normal mode done");
        loud <= 1'b1;
        wr(ADDR_CTL1, 32'h13B);
        repeat (300) @(posedge aclk);
        wr(ADDR_CTL3, 32'h100);
        rd(ADDR_STAT, RESP_OKAY, 32'h3F00, 32'h1800);
        loud <= 1'b0;
        repeat (4600) @(posedge aclk);
        rd(ADDR_VOL, RESP_OKAY, '1, 32'h18);
        wr(ADDR_CTL1, 32'h038);
        r = {1'b1, 5'($random(seed))};
        wr(ADDR_VOL, 32'(r));
        rd(ADDR_VOL, RESP_OKAY, '1, 32'(r));
        wr(ADDR_CTL1, 32'h138);
        rd(ADDR_STAT, RESP_OKAY, 32'h3F00, 32'({r, 8'h00}));
        loud <= 1'b1;
        meas(n);
        `CHK(n, LIM_ATK_CYC)
        wr(ADDR_SRATE, 32'h1);
        meas(n);
        `CHK(n > LIM_ATK_CYC, 1'b1)
        $display("limiter mode done");
        finish_test();
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        finish_test();
    end
endmodule : aiglc_core_tb
